// ### rtl/bldc_pkg.sv
`default_nettype none
package bldc_pkg;

	// Clock and timing figures in their own units, with cycle counts derived from them.
	localparam int CLK_PERIOD_NS  = 10;
	localparam int PWM_FREQ_HZ    = 10000;
	localparam int PWM_CYC        = 1000000000 / (PWM_FREQ_HZ * CLK_PERIOD_NS);
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYC       = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

	// Widths of the counters and data paths.
	localparam int DUTY_W = 14;
	localparam int TICK_W = 17;
	localparam int SPD_W  = 16;
	localparam int GAIN_W = 16;
	localparam int DAC_W  = 6;

	// Duty range is zero up to one whole PWM period.
	localparam logic [DUTY_W-1:0] DUTY_MAX = DUTY_W'(PWM_CYC);

	// Controller gains after reset, and the scaling of the controller output.
	localparam logic [GAIN_W-1:0] KP_DEFAULT = 16'h000a;
	localparam logic [GAIN_W-1:0] KI_DEFAULT = 16'h0001;
	localparam int                PI_SHIFT   = 4;
	localparam logic signed [32:0] SUM_MAX   = 33'(PWM_CYC * 16);

	// Hall weights: sensor three is 0x04, two is 0x02, one is 0x01.
	localparam int HALL3_BIT = 2;
	localparam int HALL_SENSOR_TWO_BIT = 1;
	localparam int HALL1_BIT = 0;

	// Hall value to sector vector; 000 and 111 give vector zero.
	localparam logic [2:0] VECTOR_TABLE [0:7] = '{3'h0, 3'h4, 3'h2, 3'h3, 3'h6, 3'h5, 3'h1, 3'h0};

	// Phase masks per vector: bit 0 is phase A, bit 1 is B, bit 2 is C.
	localparam logic [2:0] CW_HI  [0:7] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h0};
	localparam logic [2:0] CW_LO  [0:7] = '{3'h0, 3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h0};
	localparam logic [2:0] CCW_HI [0:7] = '{3'h0, 3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h0};
	localparam logic [2:0] CCW_LO [0:7] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h0};

	// Speed scaling: speed equals this numerator over PWM periods per sector.
	localparam int N_MAX_RPM  = 100000;
	localparam int POLE_PAIRS = 2;
	localparam int SPEED_NUM  = (PWM_FREQ_HZ * 60 / 6 / POLE_PAIRS) * 32768 / N_MAX_RPM;
	localparam int FLT_SHIFT  = 2;
	localparam logic [SPD_W-1:0] SECTOR_CNT_MAX = 16'hffff;

endpackage : bldc_pkg
`default_nettype wire

// ### rtl/pi_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pi_if;
	logic                              tick;
	logic signed [bldc_pkg::SPD_W:0]   err;
	logic [bldc_pkg::GAIN_W-1:0]       kp;
	logic [bldc_pkg::GAIN_W-1:0]       ki;
	logic [bldc_pkg::DUTY_W-1:0]       duty;
	logic                              done;

	modport ctl (output tick, output err, output kp, output ki, input duty, input done);
	modport pi  (input tick, input err, input kp, input ki, output duty, output done);
endinterface : pi_if
`default_nettype wire

// ### rtl/speed_pi.sv
`timescale 1ns/10ps
`default_nettype none
module speed_pi (
	input  wire logic mclk,
	input  wire logic sys_rst,
	pi_if.pi          bus
);

	logic signed [31:0]                 integ_q;
	logic [bldc_pkg::DUTY_W-1:0]        duty_q;
	logic                               done_q;
	logic signed [32:0]                 sum_raw;
	logic signed [31:0]                 sum_sat;
	logic signed [33:0]                 p_term;
	logic signed [49:0]                 i_term;
	logic signed [50:0]                 u_raw;
	logic signed [50:0]                 u_sh;
	logic [bldc_pkg::DUTY_W-1:0]        duty_next;

	// Running sum is clamped so a long stall cannot wind it up or overflow it.
	assign sum_raw = 33'(integ_q) + 33'(bus.err);
	assign sum_sat = (sum_raw > bldc_pkg::SUM_MAX)  ? 32'(bldc_pkg::SUM_MAX) :
	                 (sum_raw < -bldc_pkg::SUM_MAX) ? 32'(-bldc_pkg::SUM_MAX) :
	                 sum_raw[31:0];

	// Output is kp times error plus ki times the sum, scaled down and clamped to the duty range.
	assign p_term    = 34'($signed({1'b0, bus.kp})) * 34'(bus.err);
	assign i_term    = 50'($signed({1'b0, bus.ki})) * 50'(sum_sat);
	assign u_raw     = 51'(i_term) + 51'(p_term);
	assign u_sh      = u_raw >>> bldc_pkg::PI_SHIFT;
	assign duty_next = (u_sh < 0) ? '0 :
	                   (u_sh > 51'(bldc_pkg::DUTY_MAX)) ? bldc_pkg::DUTY_MAX :
	                   u_sh[bldc_pkg::DUTY_W-1:0];

	// One controller step per tick; the result waits here for the next PWM wrap.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			integ_q <= 32'h0;
			duty_q  <= '0;
			done_q  <= 1'b0;
		end else begin
			done_q <= bus.tick;
			if (bus.tick) begin
				integ_q <= sum_sat;
				duty_q  <= duty_next;
			end
		end
	end

	assign bus.duty = duty_q;
	assign bus.done = done_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_duty_range;
		duty_q <= bldc_pkg::DUTY_MAX && integ_q <= 32'(bldc_pkg::SUM_MAX);
	endproperty
	a_duty_range : assert property (p_duty_range) else $error("PI result outside duty range.");

	property p_step_once;
		bus.tick |=> done_q && duty_q == $past(duty_next) ##1 !done_q;
	endproperty
	a_step_once : assert property (p_step_once) else $error("PI step did not load once.");

	property p_hold_between;
		!bus.tick |=> $stable(duty_q) && $stable(integ_q);
	endproperty
	a_hold_between : assert property (p_hold_between) else $error("PI state moved off tick.");

endmodule : speed_pi
`default_nettype wire

// ### rtl/hall_six_step.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - error is reference minus filtered speed
// - PI result becomes the duty command
// - PI step runs once every 1 ms
// - output is kp*error plus ki*error sum
// - gains default 10 and 1, reloadable
// - duty applied only at PWM period wrap
// - hall value weights three, two, one
// - hall value indexes fixed vector table
// - patterns 000 and 111 give vector zero
// - clockwise phase pairs per vector
// - counterclockwise phase pairs per vector
// - phase pair follows every sector change
// - high side modulated, low side held on
// - only one switch modulated at once
// - edge aligned high true 10 kHz PWM
// - overcurrent forces all gates low immediately
// - speed is constant over sector period
module hall_six_step #(
	parameter int PWM_PERIOD    = bldc_pkg::PWM_CYC,
	parameter int TICK_CYCLES   = bldc_pkg::TICK_CYC
) (
	input  wire logic                          mclk,
	input  wire logic                          sys_rst,
	input  wire logic                          hall_sensor_one,
	input  wire logic                          hall_sensor_two,
	input  wire logic                          hall_sensor_three,
	input  wire logic                          dir_ccw,
	input  wire logic                          current_comparator,
	input  wire logic                          fault_clear,
	input  wire logic signed [bldc_pkg::SPD_W-1:0] ramped_speed_reference,
	input  wire logic                          gain_load,
	input  wire logic [bldc_pkg::GAIN_W-1:0]   kp_in,
	input  wire logic [bldc_pkg::GAIN_W-1:0]   ki_in,
	input  wire logic [bldc_pkg::DAC_W-1:0]    limit_dac_code,
	output logic [2:0]                         gate_high,
	output logic [2:0]                         gate_low,
	output logic [2:0]                         sector_vector,
	output logic [bldc_pkg::DUTY_W-1:0]        duty_command,
	output logic signed [bldc_pkg::SPD_W-1:0]  filtered_measured_speed,
	output logic [bldc_pkg::DAC_W-1:0]         comparator_dac_code,
	output logic                               fault
);

	pi_if pi_bus ();

	logic [2:0]                         hall_s1_q;
	logic [2:0]                         hall_s2_q;
	logic                               oc_s1_q;
	logic                               oc_s2_q;
	logic                               dir_s1_q;
	logic                               dir_s2_q;
	logic [2:0]                         vector_q;
	logic [2:0]                         vector_d;
	logic [bldc_pkg::DUTY_W-1:0]        pwm_cnt_q;
	logic [bldc_pkg::DUTY_W-1:0]        duty_q;
	logic [bldc_pkg::TICK_W-1:0]        tick_cnt_q;
	logic                               tick_q;
	logic [bldc_pkg::SPD_W-1:0]         sector_cnt_q;
	logic [bldc_pkg::SPD_W-1:0]         period_q;
	logic signed [bldc_pkg::SPD_W-1:0]  flt_q;
	logic [bldc_pkg::GAIN_W-1:0]        kp_q;
	logic [bldc_pkg::GAIN_W-1:0]        ki_q;
	logic                               fault_q;
	logic [2:0]                         gate_high_q;
	logic [2:0]                         gate_low_q;
	logic [bldc_pkg::DAC_W-1:0]         dac_q;
	logic                               pwm_wrap;
	logic                               tick_end;
	logic                               pwm_on;
	logic                               sector_change;
	logic                               shutdown;
	logic [2:0]                         hi_mask;
	logic [2:0]                         lo_mask;
	logic [bldc_pkg::SPD_W-1:0]         speed_act;
	logic signed [bldc_pkg::SPD_W:0]    flt_diff;
	logic signed [bldc_pkg::SPD_W:0]    flt_step;

	// Hall, comparator and direction pins pass two flip-flops; hall three lands on the 0x04 weight.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			hall_s1_q <= 3'h0;
			hall_s2_q <= 3'h0;
			oc_s1_q   <= 1'b0;
			oc_s2_q   <= 1'b0;
			dir_s1_q  <= 1'b0;
			dir_s2_q  <= 1'b0;
		end else begin
			hall_s1_q[bldc_pkg::HALL3_BIT] <= hall_sensor_three;
			hall_s1_q[bldc_pkg::HALL_SENSOR_TWO_BIT] <= hall_sensor_two;
			hall_s1_q[bldc_pkg::HALL1_BIT] <= hall_sensor_one;
			hall_s2_q <= hall_s1_q;
			oc_s1_q   <= current_comparator;
			oc_s2_q   <= oc_s1_q;
			dir_s1_q  <= dir_ccw;
			dir_s2_q  <= dir_s1_q;
		end
	end

	// Sector decode and phase-pair selection are pure table lookups.
	assign vector_d      = bldc_pkg::VECTOR_TABLE[hall_s2_q];
	assign sector_change = (vector_d != vector_q) && (vector_d != 3'h0);
	assign hi_mask       = dir_s2_q ? bldc_pkg::CCW_HI[vector_q] : bldc_pkg::CW_HI[vector_q];
	assign lo_mask       = dir_s2_q ? bldc_pkg::CCW_LO[vector_q] : bldc_pkg::CW_LO[vector_q];

	// Edge-aligned counter; the output is high while the count is below the duty.
	assign pwm_wrap = (pwm_cnt_q == bldc_pkg::DUTY_W'(PWM_PERIOD - 1));
	assign pwm_on   = (pwm_cnt_q < duty_q);
	assign tick_end = (tick_cnt_q == bldc_pkg::TICK_W'(TICK_CYCLES - 1));

	// The comparator is acted on in the same cycle it is seen, before the fault flag sets.
	assign shutdown = fault_q | oc_s2_q;

	// Speed is a division by the period; a zero period cannot occur as period_q is kept at least one.
	assign speed_act = bldc_pkg::SPD_W'(bldc_pkg::SPEED_NUM / int'(period_q));
	assign flt_diff  = $signed({1'b0, speed_act}) - 17'(flt_q);
	assign flt_step  = flt_diff >>> bldc_pkg::FLT_SHIFT;

	// Speed error is formed from the live filtered value at each tick.
	assign pi_bus.err  = 17'(ramped_speed_reference) - 17'(flt_q);
	assign pi_bus.tick = tick_q;
	assign pi_bus.kp   = kp_q;
	assign pi_bus.ki   = ki_q;

	speed_pi u_speed_pi (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.bus     (pi_bus.pi)
	);

	// PWM period counter; a new duty is taken only at the wrap so no period is cut short.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pwm_cnt_q <= '0;
			duty_q    <= '0;
		end else begin
			pwm_cnt_q <= pwm_wrap ? '0 : pwm_cnt_q + 1'b1;
			if (pwm_wrap) begin
				duty_q <= pi_bus.duty;
			end
		end
	end

	// Control tick, one pulse per millisecond.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else begin
			tick_cnt_q <= tick_end ? '0 : tick_cnt_q + 1'b1;
			tick_q     <= tick_end;
		end
	end

	// Sector period in PWM periods; the count saturates so a stalled rotor reads as slowest speed.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			vector_q     <= 3'h0;
			sector_cnt_q <= '0;
			period_q     <= bldc_pkg::SECTOR_CNT_MAX;
			flt_q        <= '0;
		end else begin
			vector_q <= vector_d;
			if (sector_change) begin
				sector_cnt_q <= '0;
				period_q     <= (sector_cnt_q == '0) ? 16'h0001 : sector_cnt_q;
			end else if (pwm_wrap && sector_cnt_q != bldc_pkg::SECTOR_CNT_MAX) begin
				sector_cnt_q <= sector_cnt_q + 1'b1;
			end else if (sector_cnt_q == bldc_pkg::SECTOR_CNT_MAX) begin
				period_q <= bldc_pkg::SECTOR_CNT_MAX;
			end
			if (pwm_wrap) begin
				flt_q <= flt_q + flt_step[bldc_pkg::SPD_W-1:0];
			end
		end
	end

	// Gains start at their defaults and are replaced when software loads new ones.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			kp_q  <= bldc_pkg::KP_DEFAULT;
			ki_q  <= bldc_pkg::KI_DEFAULT;
			dac_q <= '0;
		end else begin
			dac_q <= limit_dac_code;
			if (gain_load) begin
				kp_q <= kp_in;
				ki_q <= ki_in;
			end
		end
	end

	// Fault latch; a new comparator event wins over a clear in the same cycle.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= oc_s2_q | (fault_q & ~fault_clear);
		end
	end

	// Gate drive: high side chopped, low side held on, all off on fault or vector zero.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			gate_high_q <= 3'h0;
			gate_low_q  <= 3'h0;
		end else begin
			gate_high_q <= shutdown ? 3'h0 : (hi_mask & {3{pwm_on}});
			gate_low_q  <= shutdown ? 3'h0 : lo_mask;
		end
	end

	assign gate_high               = gate_high_q;
	assign gate_low                = gate_low_q;
	assign sector_vector           = vector_q;
	assign duty_command            = duty_q;
	assign filtered_measured_speed = flt_q;
	assign comparator_dac_code     = dac_q;
	assign fault                   = fault_q;

	// Helper that measures the spacing of control ticks.
	logic [bldc_pkg::TICK_W-1:0] gap_q;
	logic                        seen_q;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			gap_q  <= '0;
			seen_q <= 1'b0;
		end else begin
			gap_q  <= tick_q ? '0 : gap_q + 1'b1;
			seen_q <= seen_q | tick_q;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_overcurrent;
		oc_s2_q;
	endsequence

	sequence s_gates_dead;
		gate_high_q == 3'h0 && gate_low_q == 3'h0;
	endsequence

	property p_fault_off;
		s_overcurrent |=> s_gates_dead ##1 s_gates_dead;
	endproperty
	a_fault_off : assert property (p_fault_off) else $error("Gates not off after overcurrent.");

	property p_vector_map;
		##1 vector_q == bldc_pkg::VECTOR_TABLE[$past(hall_s2_q)];
	endproperty
	a_vector_map : assert property (p_vector_map) else $error("Sector vector does not follow hall table.");

	property p_invalid_off;
		vector_q == 3'h0 |=> s_gates_dead;
	endproperty
	a_invalid_off : assert property (p_invalid_off) else $error("Gates on with vector zero.");

	property p_one_pwm;
		$onehot0(gate_high_q) && $onehot0(gate_low_q) && (gate_high_q & gate_low_q) == 3'h0;
	endproperty
	a_one_pwm : assert property (p_one_pwm) else $error("More than one switch per side active.");

	property p_duty_at_wrap;
		!pwm_wrap |=> $stable(duty_q);
	endproperty
	a_duty_at_wrap : assert property (p_duty_at_wrap) else $error("Duty changed away from wrap.");

	property p_tick_period;
		tick_q && seen_q |-> gap_q == bldc_pkg::TICK_W'(TICK_CYCLES - 1);
	endproperty
	a_tick_period : assert property (p_tick_period) else $error("Control tick spacing wrong.");

	property p_cw_first;
		!shutdown && !dir_s2_q && vector_q == 3'h1 |=> gate_low_q == 3'h2;
	endproperty
	a_cw_first : assert property (p_cw_first) else $error("Clockwise vector one not A+B-.");

	property p_ccw_first;
		!shutdown && dir_s2_q && vector_q == 3'h1 |=> gate_low_q == 3'h1;
	endproperty
	a_ccw_first : assert property (p_ccw_first) else $error("Counterclockwise vector one not B+A-.");

	property p_low_held;
		$stable({shutdown, dir_s2_q, vector_q}) && !shutdown && |vector_q |=> $stable(gate_low_q);
	endproperty
	a_low_held : assert property (p_low_held) else $error("Low side moved within a sector.");

	property p_period_load;
		sector_change |=> period_q != '0 && sector_cnt_q == '0;
	endproperty
	a_period_load : assert property (p_period_load) else $error("Sector period not captured.");

endmodule : hall_six_step
`default_nettype wire

// ### dv/motor_model.sv
`timescale 1ns/10ps
`default_nettype none
// Bridge and hall sensors seen from the controller pins.
module motor_model (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [2:0] hall_req,
	input  wire logic       oc_req,
	input  wire logic [2:0] gate_high,
	input  wire logic [2:0] gate_low,
	output logic            hall_sensor_one,
	output logic            hall_sensor_two,
	output logic            hall_sensor_three,
	output logic            current_comparator,
	output logic            shoot_thru
);
	// Sensors follow the commanded rotor position; a shorted leg also trips the comparator.
	always_ff @(posedge mclk) begin
		hall_sensor_three  <= hall_req[2];
		hall_sensor_two    <= hall_req[1];
		hall_sensor_one    <= hall_req[0];
		current_comparator <= oc_req | (|(gate_high & gate_low));
	end

	// Both switches of one leg on would short the supply, so it is remembered.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			shoot_thru <= 1'b0;
		end else if (|(gate_high & gate_low)) begin
			shoot_thru <= 1'b1;
		end
	end
endmodule : motor_model
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s expected %0h got %0h", nm, e, g); end end
module tb;
	localparam int PWM_P  = 50;
	localparam int TICK_P = 200;
	localparam logic [2:0] VT [0:7] = '{3'h0, 3'h4, 3'h2, 3'h3, 3'h6, 3'h5, 3'h1, 3'h0};
	localparam logic [2:0] PH_A [0:6] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
	localparam logic [2:0] PH_B [0:6] = '{3'h0, 3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
	logic                              mclk;
	logic                              sys_rst;
	logic                              dir_ccw;
	logic                              fault_clear;
	logic                              gain_load;
	logic                              oc_req;
	logic [2:0]                        hall_req;
	logic signed [bldc_pkg::SPD_W-1:0] speed_ref;
	logic [bldc_pkg::GAIN_W-1:0]       kp_in;
	logic [bldc_pkg::GAIN_W-1:0]       ki_in;
	logic [bldc_pkg::DAC_W-1:0]        limit_dac_code;
	logic                              h1;
	logic                              h2;
	logic                              h3;
	logic                              cmp;
	logic                              shoot_thru;
	logic [2:0]                        gate_high;
	logic [2:0]                        gate_low;
	logic [2:0]                        sector_vector;
	logic [bldc_pkg::DUTY_W-1:0]       duty_command;
	logic signed [bldc_pkg::SPD_W-1:0] speed;
	logic [bldc_pkg::DAC_W-1:0]        dac_code;
	logic                              fault;
	int                                bad_count;
	int                                num_checks;

	hall_six_step #(.PWM_PERIOD(PWM_P), .TICK_CYCLES(TICK_P)) u_dut (
		.mclk(mclk), .sys_rst(sys_rst), .hall_sensor_one(h1), .hall_sensor_two(h2),
		.hall_sensor_three(h3), .dir_ccw(dir_ccw), .current_comparator(cmp),
		.fault_clear(fault_clear), .ramped_speed_reference(speed_ref), .gain_load(gain_load),
		.kp_in(kp_in), .ki_in(ki_in), .limit_dac_code(limit_dac_code), .gate_high(gate_high),
		.gate_low(gate_low), .sector_vector(sector_vector), .duty_command(duty_command),
		.filtered_measured_speed(speed), .comparator_dac_code(dac_code), .fault(fault));

	motor_model u_motor (
		.mclk(mclk), .sys_rst(sys_rst), .hall_req(hall_req), .oc_req(oc_req),
		.gate_high(gate_high), .gate_low(gate_low), .hall_sensor_one(h1),
		.hall_sensor_two(h2), .hall_sensor_three(h3), .current_comparator(cmp),
		.shoot_thru(shoot_thru));

	// Free-running system clock.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	task automatic do_reset;
		sys_rst <= 1'b1;
		cyc(8);
		sys_rst <= 1'b0;
	endtask : do_reset

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	task automatic t_reset;
		do_reset;
		`CHK("gate_high", 3'h0, gate_high) // RESET
		`CHK("gate_low", 3'h0, gate_low) // RESET
		`CHK("duty", 14'h0, duty_command) // RESET
		`CHK("fault", 1'b0, fault) // RESET
		$display("test reset done");
	endtask : t_reset

	// Every hall pattern in both directions; each step to a pattern other than 000 or 111 is a sector change.
	task automatic t_commutate;
		logic [2:0] hi;
		logic [2:0] lo;
		for (int d = 0; d < 2; d++) begin
			for (int h = 0; h < 8; h++) begin
				dir_ccw  <= d[0];
				hall_req <= h[2:0];
				cyc(8);
				hi = d ? PH_B[VT[h]] : PH_A[VT[h]];
				lo = d ? PH_A[VT[h]] : PH_B[VT[h]];
				`CHK("vector", VT[h], sector_vector)
				`CHK("gate_low", lo, gate_low)
				`CHK("gate_high", 3'h0, gate_high & ~hi)
			end
		end
		$display("test commutate done");
	endtask : t_commutate

	// One control step from reset; the duty shows as high-side on-time per period.
	task automatic t_pi(input logic ld, input logic [15:0] kp, input logic [15:0] ki,
			input logic [15:0] rf, input logic [13:0] exp_d);
		int hc;
		int exp_h;
		hall_req  <= 3'h0;
		dir_ccw   <= 1'b0;
		speed_ref <= rf;
		do_reset;
		kp_in     <= kp;
		ki_in     <= ki;
		gain_load <= ld;
		cyc(1);
		gain_load <= 1'b0;
		cyc(TICK_P - 20);
		`CHK("duty_early", 14'h0, duty_command)
		`CHK("speed", 16'h0, speed)
		cyc(80);
		`CHK("duty", exp_d, duty_command)
		hall_req <= 3'h6;
		cyc(8);
		hc = 0;
		repeat (PWM_P) begin
			cyc(1);
			if (gate_high === 3'h1) begin
				hc++;
			end
		end
		exp_h = (exp_d > PWM_P) ? PWM_P : int'(exp_d);
		`CHK("high_count", exp_h, hc)
		`CHK("gate_low", 3'h2, gate_low)
		// Five wraps before the hall step give a period of 5; one filter step is (16384/5)>>>2.
		`CHK("speed_run", 16'h0333, speed)
		$display("test pi done");
	endtask : t_pi

	// Overcurrent while driving; clearing is refused while the comparator is high.
	task automatic t_fault;
		int n;
		oc_req <= 1'b1;
		n = 0;
		while (!(fault === 1'b1 && gate_high === 3'h0 && gate_low === 3'h0) && n < 8) begin
			cyc(1);
			n++;
		end
		if (fault !== 1'b1 || (gate_high | gate_low) !== 3'h0) begin
			bad_count++;
			$display("[ERR] shutdown expected 1 got 0");
			give_verdict;
		end
		`CHK("fault", 1'b1, fault)
		fault_clear <= 1'b1;
		cyc(1);
		fault_clear <= 1'b0;
		oc_req      <= 1'b0;
		cyc(10);
		`CHK("fault_held", 1'b1, fault)
		`CHK("gates_off", 3'h0, gate_high | gate_low)
		fault_clear <= 1'b1;
		cyc(1);
		fault_clear <= 1'b0;
		cyc(8);
		`CHK("fault_clr", 1'b0, fault)
		`CHK("gate_low", 3'h2, gate_low)
		$display("test fault done");
	endtask : t_fault

	task automatic t_dac;
		limit_dac_code <= 6'h21;
		cyc(3);
		`CHK("dac", 6'h21, dac_code)
		$display("test dac done");
	endtask : t_dac

	// Main sequence; the watchdog below cuts a hang short.
	initial begin
		sys_rst        = 1'b1;
		dir_ccw        = 1'b0;
		fault_clear    = 1'b0;
		gain_load      = 1'b0;
		oc_req         = 1'b0;
		hall_req       = 3'h0;
		speed_ref      = 16'h0;
		kp_in          = 16'h0;
		ki_in          = 16'h0;
		limit_dac_code = 6'h0;
		bad_count      = 0;
		num_checks     = 0;
		@(posedge mclk);
		t_reset;
		t_commutate;
		t_pi(1'b0, 16'h0, 16'h0, 16'h0040, 14'h002c);
		t_pi(1'b1, 16'h0010, 16'h0000, 16'h0020, 14'h0020);
		t_pi(1'b0, 16'h0, 16'h0, 16'hffc0, 14'h0000);
		t_pi(1'b0, 16'h0, 16'h0, 16'h7fff, 14'h2710);
		t_fault;
		t_dac;
		`CHK("shoot_thru", 1'b0, shoot_thru)
		give_verdict;
	end

	initial begin
		cyc(50000);
		bad_count++;
		$display("[ERR] watchdog expected end got hang");
		give_verdict;
	end
endmodule : tb
`default_nettype wire
